// File: rtl/ssba_regs.svh
`ifndef SSBA_REGS_SVH
`define SSBA_REGS_SVH

// ----------------------------------------------------------------
// Address constants
// ----------------------------------------------------------------
`define SSBA_FRU_BASE 4'hA
`define SSBA_FRU_FIXED_LSB 1'h0
`define SSBA_DIE_STEP 3'h4
`define SSBA_PID_DIE_BIT 2
`define SSBA_CHAN_PID_MSB 7
`define SSBA_CHAN_PID_LSB 5

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SSBA_RST_SLOT 2'h0
`define SSBA_RST_SMB_ADDR 7'h00
`define SSBA_RST_PID 3'h0
`define SSBA_CAP_WAIT 2'h2
`define SSBA_NREQ 4

`endif

// File: rtl/ssba_pkg.sv
`default_nettype none
package ssba_pkg;

    typedef enum logic [1:0] {
        SSBA_PM_OFF,
        SSBA_PM_ID,
        SSBA_PM_AUX,
        SSBA_PM_MAIN
    } ssba_pwr_t;

    typedef enum logic [1:0] {
        SSBA_AT_NONE,
        SSBA_AT_FIXED,
        SSBA_AT_DYN_PERSIST,
        SSBA_AT_DYN_VOLATILE
    } ssba_addr_type_t;

    typedef enum logic [1:0] {
        SSBA_SB_IDLE,
        SSBA_SB_CHECK,
        SSBA_SB_RUN,
        SSBA_SB_DENY
    } ssba_boot_t;

endpackage : ssba_pkg
`default_nettype wire

// File: rtl/ssba_slot_capture.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssba_regs.svh"

module ssba_slot_capture (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Baseboard slot pins
    input wire logic slot_position_upper,
    input wire logic slot_position_lower,
    // Captured value
    output logic [1:0] slot_position_bits,
    output logic captured
);

    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] wait_q;
    logic [1:0] slot_q;
    logic cap_q;

    // The pins are static, so one capture after reset is enough and later glitches are ignored.
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_q <= `SSBA_RST_SLOT;
            sync2_q <= `SSBA_RST_SLOT;
            wait_q <= 2'h0;
            slot_q <= `SSBA_RST_SLOT;
            cap_q <= 1'b0;
        end else begin
            sync1_q <= {slot_position_upper, slot_position_lower};
            sync2_q <= sync1_q;
            if (wait_q != `SSBA_CAP_WAIT) begin
                wait_q <= wait_q + 2'h1;
            end else if (!cap_q) begin
                slot_q <= sync2_q;
                cap_q <= 1'b1;
            end
        end
    end

    assign slot_position_bits = slot_q;
    assign captured = cap_q;

endmodule : ssba_slot_capture
`default_nettype wire

// File: rtl/ssba_fw_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssba_regs.svh"

module ssba_fw_arbiter (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Requesters
    input wire logic [`SSBA_NREQ-1:0] wr_req,
    input wire logic [`SSBA_NREQ-1:0] wr_done,
    // Answers
    output logic [`SSBA_NREQ-1:0] wr_grant,
    output logic [`SSBA_NREQ-1:0] wr_reject
);

    logic [`SSBA_NREQ-1:0] grant_q;
    logic [`SSBA_NREQ-1:0] reject_q;
    logic [`SSBA_NREQ-1:0] req_prev_q;
    logic [`SSBA_NREQ-1:0] pick;
    logic [`SSBA_NREQ-1:0] req_rise;
    logic locked;
    logic release_now;

    // Lowest index wins when several ask in the same cycle.
    assign pick = wr_req & (~wr_req + `SSBA_NREQ'h1);
    assign req_rise = wr_req & ~req_prev_q;
    assign locked = |grant_q;
    assign release_now = |(grant_q & (wr_done | ~wr_req));

    always_ff @(posedge mclk) begin
        if (rst) begin
            grant_q <= `SSBA_NREQ'h0;
            reject_q <= `SSBA_NREQ'h0;
            req_prev_q <= `SSBA_NREQ'h0;
        end else begin
            req_prev_q <= wr_req;
            if (release_now) begin
                grant_q <= `SSBA_NREQ'h0;
                reject_q <= `SSBA_NREQ'h0;
            end else if (!locked) begin
                grant_q <= pick;
                reject_q <= req_rise & ~pick;
            end else begin
                reject_q <= req_rise & ~grant_q;
            end
        end
    end

    assign wr_grant = grant_q;
    assign wr_reject = reject_q;

endmodule : ssba_fw_arbiter
`default_nettype wire

// File: rtl/ssba_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssba_regs.svh"

module ssba_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Slot pins from the baseboard
    input wire logic slot_position_upper,
    input wire logic slot_position_lower,
    // Die population
    input wire logic second_die_present,
    input wire logic die_bit2_forced,
    // NC-SI channel lookup
    input wire logic ncsi_chan_valid,
    input wire logic [7:0] ncsi_chan_id,
    // Arbitration ring
    input wire logic arb_ring_in,
    input wire logic ncsi_tx_pending,
    input wire logic ncsi_tx_done,
    // Power state
    input wire ssba_pkg::ssba_pwr_t power_mode,
    // SMBus address resolution events
    input wire logic fixed_mode_cfg,
    input wire logic [6:0] fixed_addr_cfg,
    input wire logic arp_persist_cfg,
    input wire logic arp_assign_valid,
    input wire logic [6:0] arp_assign_addr,
    input wire logic arp_reset_valid,
    // MCTP transport
    input wire logic mctp_tx_req,
    input wire logic smbus20_mode,
    // Firmware write requesters
    input wire logic [`SSBA_NREQ-1:0] fw_wr_req,
    input wire logic [`SSBA_NREQ-1:0] fw_wr_done,
    // Inventory queries
    input wire logic [`SSBA_NREQ-1:0] inv_req,
    // Secure boot
    input wire logic secure_en,
    input wire logic comp_load,
    input wire logic verify_done,
    input wire logic verify_pass,
    // Package identifiers
    output logic [2:0] pkg_id_die0,
    output logic [2:0] pkg_id_die1,
    output logic die1_enable,
    output logic die_conflict,
    output logic ids_valid,
    output logic ncsi_match_die0,
    output logic ncsi_match_die1,
    // Ring and NC-SI transmit
    output logic arb_ring_out,
    output logic ncsi_tx_grant,
    // FRU EEPROM
    output logic eeprom_addr_strap_high,
    output logic eeprom_addr_strap_mid,
    output logic eeprom_addr_strap_low,
    output logic [7:0] fru_addr_wr,
    output logic [7:0] fru_addr_rd,
    output logic fru_read_enable,
    // SMBus target address
    output logic [6:0] smb_addr,
    output logic smb_addr_valid,
    output ssba_pkg::ssba_addr_type_t smb_addr_type,
    output logic arp_participate,
    output logic arp_resolved,
    // MCTP
    output logic mctp_tx_grant,
    output logic mctp_tx_refused,
    // Firmware writes
    output logic [`SSBA_NREQ-1:0] fw_wr_grant,
    output logic [`SSBA_NREQ-1:0] fw_wr_reject,
    // Inventory answers
    output logic [`SSBA_NREQ-1:0] inv_ack,
    output logic [1:0] inv_src,
    // Secure boot
    output logic verify_start,
    output logic comp_run,
    output logic comp_deny
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic pid_hit(input logic [7:0] chan, input logic [2:0] pid);
        pid_hit = (chan[`SSBA_CHAN_PID_MSB:`SSBA_CHAN_PID_LSB] == pid);
    endfunction : pid_hit

    // Returns the first requester at or after ptr, with a found flag on top.
    function automatic logic [2:0] rr_pick(input logic [3:0] req, input logic [1:0] ptr);
        logic [2:0] res;
        logic [1:0] idx;
        res = 3'h0;
        idx = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            idx = ptr + i[1:0];
            if (req[idx]) begin
                res = {1'b1, idx};
            end
        end
        rr_pick = res;
    endfunction : rr_pick

    // ----------------------------------------------------------------
    // Slot capture
    // ----------------------------------------------------------------
    logic [1:0] slot_bits;
    logic slot_captured;

    // The slot pins must be static; a change after capture is not seen until the next reset.
    ssba_slot_capture u_slot (
        .mclk(mclk),
        .rst(rst),
        .slot_position_upper(slot_position_upper),
        .slot_position_lower(slot_position_lower),
        .slot_position_bits(slot_bits),
        .captured(slot_captured)
    );

    // ----------------------------------------------------------------
    // Package identifiers
    // ----------------------------------------------------------------
    wire [2:0] pid0_d = {1'b0, slot_bits};
    wire [2:0] pid1_d = pid0_d + `SSBA_DIE_STEP;
    wire die1_ok = second_die_present & ~die_bit2_forced;
    wire conflict_d = second_die_present & die_bit2_forced;

    logic [2:0] pid0_q;
    logic [2:0] pid1_q;
    logic die1_en_q;
    logic conflict_q;
    logic ids_valid_q;

    // The ids are loaded once, so the addresses stay put for the whole run.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pid0_q <= `SSBA_RST_PID;
            pid1_q <= `SSBA_RST_PID;
            die1_en_q <= 1'b0;
            conflict_q <= 1'b0;
            ids_valid_q <= 1'b0;
        end else if (slot_captured && !ids_valid_q) begin
            pid0_q <= pid0_d;
            pid1_q <= pid1_d;
            die1_en_q <= die1_ok;
            conflict_q <= conflict_d;
            ids_valid_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Channel match
    // ----------------------------------------------------------------
    wire match0_d = ncsi_chan_valid & ids_valid_q & pid_hit(ncsi_chan_id, pid0_q);
    wire match1_d = ncsi_chan_valid & die1_en_q & pid_hit(ncsi_chan_id, pid1_q);

    logic match0_q;
    logic match1_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            match0_q <= 1'b0;
            match1_q <= 1'b0;
        end else begin
            match0_q <= match0_d;
            match1_q <= match1_d;
        end
    end

    // ----------------------------------------------------------------
    // Arbitration ring
    // ----------------------------------------------------------------
    logic ring_s1_q;
    logic ring_s2_q;
    logic ring_hold_q;
    logic ring_out_q;

    wire ring_take = ring_s2_q & ncsi_tx_pending & ~ring_hold_q;

    // The token is forwarded unless this card holds it, so an empty neighbour never breaks the chain.
    always_ff @(posedge mclk) begin
        if (rst) begin
            ring_s1_q <= 1'b0;
            ring_s2_q <= 1'b0;
            ring_hold_q <= 1'b0;
            ring_out_q <= 1'b0;
        end else begin
            ring_s1_q <= arb_ring_in;
            ring_s2_q <= ring_s1_q;
            if (ring_take) begin
                ring_hold_q <= 1'b1;
            end else if (ncsi_tx_done) begin
                ring_hold_q <= 1'b0;
            end
            ring_out_q <= ring_s2_q & ~(ring_hold_q | ring_take);
        end
    end

    // ----------------------------------------------------------------
    // FRU EEPROM address
    // ----------------------------------------------------------------
    wire [6:0] fru7_d = {`SSBA_FRU_BASE, slot_bits, `SSBA_FRU_FIXED_LSB};
    wire fru_mode_ok = (power_mode != ssba_pkg::SSBA_PM_OFF);

    logic [6:0] fru7_q;
    logic fru_rd_en_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            fru7_q <= {`SSBA_FRU_BASE, 3'h0};
            fru_rd_en_q <= 1'b0;
        end else begin
            if (slot_captured && !ids_valid_q) begin
                fru7_q <= fru7_d;
            end
            fru_rd_en_q <= fru_mode_ok & ids_valid_q;
        end
    end

    // ----------------------------------------------------------------
    // SMBus target address
    // ----------------------------------------------------------------
    logic [6:0] smb_addr_q;
    logic smb_valid_q;
    ssba_pkg::ssba_addr_type_t smb_type_q;
    logic resolved_q;

    wire is_volatile = (smb_type_q == ssba_pkg::SSBA_AT_DYN_VOLATILE);
    wire vol_lost = is_volatile & (arp_reset_valid | (power_mode == ssba_pkg::SSBA_PM_OFF));
    wire assign_type_persist = arp_persist_cfg;

    // A new assignment in the same cycle as a reset command wins, so the assignment is lost only while fixed_mode_cfg is set.
    always_ff @(posedge mclk) begin
        if (rst) begin
            smb_addr_q <= `SSBA_RST_SMB_ADDR;
            smb_valid_q <= 1'b0;
            smb_type_q <= ssba_pkg::SSBA_AT_NONE;
            resolved_q <= 1'b0;
        end else if (fixed_mode_cfg) begin
            smb_addr_q <= fixed_addr_cfg;
            smb_valid_q <= 1'b1;
            smb_type_q <= ssba_pkg::SSBA_AT_FIXED;
            resolved_q <= 1'b0;
        end else if (arp_assign_valid) begin
            smb_addr_q <= arp_assign_addr;
            smb_valid_q <= 1'b1;
            resolved_q <= 1'b1;
            if (assign_type_persist) begin
                smb_type_q <= ssba_pkg::SSBA_AT_DYN_PERSIST;
            end else begin
                smb_type_q <= ssba_pkg::SSBA_AT_DYN_VOLATILE;
            end
        end else if (vol_lost) begin
            smb_valid_q <= 1'b0;
            smb_type_q <= ssba_pkg::SSBA_AT_NONE;
            resolved_q <= 1'b0;
        end else if (smb_type_q == ssba_pkg::SSBA_AT_FIXED) begin
            smb_valid_q <= 1'b0;
            smb_type_q <= ssba_pkg::SSBA_AT_NONE;
        end else if (arp_reset_valid) begin
            resolved_q <= 1'b0;
        end
    end

    logic arp_part_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            arp_part_q <= 1'b0;
        end else begin
            arp_part_q <= fru_mode_ok;
        end
    end

    // ----------------------------------------------------------------
    // MCTP transport gate
    // ----------------------------------------------------------------
    wire mctp_ok = smbus20_mode & smb_valid_q;

    logic mctp_grant_q;
    logic mctp_refused_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            mctp_grant_q <= 1'b0;
            mctp_refused_q <= 1'b0;
        end else begin
            mctp_grant_q <= mctp_tx_req & mctp_ok;
            mctp_refused_q <= mctp_tx_req & ~mctp_ok;
        end
    end

    // ----------------------------------------------------------------
    // Firmware write arbitration
    // ----------------------------------------------------------------
    ssba_fw_arbiter u_arb (
        .mclk(mclk),
        .rst(rst),
        .wr_req(fw_wr_req),
        .wr_done(fw_wr_done),
        .wr_grant(fw_wr_grant),
        .wr_reject(fw_wr_reject)
    );

    // ----------------------------------------------------------------
    // Inventory queries
    // ----------------------------------------------------------------
    logic [1:0] inv_ptr_q;
    logic [3:0] inv_ack_q;
    logic [1:0] inv_src_q;

    // Requests acked last cycle are masked for one cycle and the pointer moves past each winner, so a held request can't starve.
    wire [3:0] inv_open = inv_req & ~inv_ack_q;
    wire [2:0] inv_pick = rr_pick(inv_open, inv_ptr_q);

    always_ff @(posedge mclk) begin
        if (rst) begin
            inv_ptr_q <= 2'h0;
            inv_ack_q <= 4'h0;
            inv_src_q <= 2'h0;
        end else begin
            inv_ack_q <= 4'h0;
            if (inv_pick[2]) begin
                inv_ack_q <= 4'h1 << inv_pick[1:0];
                inv_src_q <= inv_pick[1:0];
                inv_ptr_q <= inv_pick[1:0] + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Secure boot gate
    // ----------------------------------------------------------------
    ssba_pkg::ssba_boot_t sb_q;
    ssba_pkg::ssba_boot_t sb_d;
    logic vstart_q;
    logic deny_q;

    always_comb begin
        sb_d = sb_q;
        unique case (sb_q)
            ssba_pkg::SSBA_SB_IDLE,
            ssba_pkg::SSBA_SB_RUN,
            ssba_pkg::SSBA_SB_DENY: begin
                if (comp_load) begin
                    sb_d = secure_en ? ssba_pkg::SSBA_SB_CHECK : ssba_pkg::SSBA_SB_RUN;
                end
            end
            ssba_pkg::SSBA_SB_CHECK: begin
                if (verify_done) begin
                    sb_d = verify_pass ? ssba_pkg::SSBA_SB_RUN : ssba_pkg::SSBA_SB_DENY;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sb_q <= ssba_pkg::SSBA_SB_IDLE;
            vstart_q <= 1'b0;
            deny_q <= 1'b0;
        end else begin
            sb_q <= sb_d;
            vstart_q <= (sb_d == ssba_pkg::SSBA_SB_CHECK) && (sb_q != ssba_pkg::SSBA_SB_CHECK);
            deny_q <= (sb_d == ssba_pkg::SSBA_SB_DENY) && (sb_q == ssba_pkg::SSBA_SB_CHECK);
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign pkg_id_die0 = pid0_q;
    assign pkg_id_die1 = pid1_q;
    assign die1_enable = die1_en_q;
    assign die_conflict = conflict_q;
    assign ids_valid = ids_valid_q;
    assign ncsi_match_die0 = match0_q;
    assign ncsi_match_die1 = match1_q;
    assign arb_ring_out = ring_out_q;
    assign ncsi_tx_grant = ring_hold_q;
    assign eeprom_addr_strap_high = fru7_q[2];
    assign eeprom_addr_strap_mid = fru7_q[1];
    assign eeprom_addr_strap_low = fru7_q[0];
    assign fru_addr_wr = {fru7_q, 1'b0};
    assign fru_addr_rd = {fru7_q, 1'b1};
    assign fru_read_enable = fru_rd_en_q;
    assign smb_addr = smb_addr_q;
    assign smb_addr_valid = smb_valid_q;
    assign smb_addr_type = smb_type_q;
    assign arp_participate = arp_part_q;
    assign arp_resolved = resolved_q;
    assign mctp_tx_grant = mctp_grant_q;
    assign mctp_tx_refused = mctp_refused_q;
    assign inv_ack = inv_ack_q;
    assign inv_src = inv_src_q;
    assign verify_start = vstart_q;
    assign comp_run = (sb_q == ssba_pkg::SSBA_SB_RUN);
    assign comp_deny = deny_q;

endmodule : ssba_top
`default_nettype wire

// File: test/ssba_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ssba_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Identifiers
    input wire logic ids_valid,
    input wire logic die1_enable,
    input wire logic [2:0] pkg_id_die0,
    input wire logic [2:0] pkg_id_die1,
    input wire logic eeprom_addr_strap_high,
    input wire logic eeprom_addr_strap_mid,
    input wire logic eeprom_addr_strap_low,
    input wire logic [7:0] fru_addr_wr,
    input wire logic [7:0] fru_addr_rd,
    // Channel lookup
    input wire logic ncsi_chan_valid,
    input wire logic [7:0] ncsi_chan_id,
    input wire logic ncsi_match_die0,
    // Firmware writes and transport
    input wire logic [3:0] fw_wr_req,
    input wire logic [3:0] fw_wr_done,
    input wire logic [3:0] fw_wr_grant,
    input wire logic mctp_tx_req,
    input wire logic smbus20_mode,
    input wire logic mctp_tx_grant,
    input wire logic mctp_tx_refused
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);

    property p_pid;
        ids_valid |-> pkg_id_die0 == {1'h0, eeprom_addr_strap_high, eeprom_addr_strap_mid};
    endproperty
    a_pid: assert property (p_pid) else $error("die0 id does not follow slot");
    property p_step;
        ids_valid && die1_enable |-> pkg_id_die1 == pkg_id_die0 + 3'h4;
    endproperty
    a_step: assert property (p_step) else $error("die1 id not four above die0");
    property p_match;
        ids_valid && ncsi_chan_valid |=> ncsi_match_die0 == (($past(ncsi_chan_id) >> 5) == {5'h00, pkg_id_die0});
    endproperty
    a_match: assert property (p_match) else $error("channel match wrong");
    property p_fru;
        ids_valid |-> fru_addr_wr == {4'hA, eeprom_addr_strap_high, eeprom_addr_strap_mid, 2'h0}
            && fru_addr_rd == (fru_addr_wr | 8'h01) && !eeprom_addr_strap_low;
    endproperty
    a_fru: assert property (p_fru) else $error("eeprom address wrong");
    property p_fw_one;
        fw_wr_grant != 4'h0 |-> $onehot(fw_wr_grant);
    endproperty
    a_fw_one: assert property (p_fw_one) else $error("two writers granted");
    property p_fw_keep;
        (fw_wr_grant & fw_wr_req & ~fw_wr_done) != 4'h0 |=> fw_wr_grant == $past(fw_wr_grant);
    endproperty
    a_fw_keep: assert property (p_fw_keep) else $error("writer lost grant");
    property p_mctp;
        mctp_tx_req && !smbus20_mode |=> !mctp_tx_grant && mctp_tx_refused;
    endproperty
    a_mctp: assert property (p_mctp) else $error("transport over plain bus");
    property p_hold;
        ids_valid && $past(ids_valid) |-> $stable(pkg_id_die0) && $stable(fru_addr_wr);
    endproperty
    a_hold: assert property (p_hold) else $error("ids changed after capture");
endmodule : ssba_monitor

bind ssba_top ssba_monitor u_monitor (.*);
`default_nettype wire

// File: test/ssba_bmc_model.sv
`timescale 1ns/100ps
`default_nettype none
module ssba_bmc_model (
    // Clock and straps
    input wire logic mclk,
    input wire logic [1:0] slot_sel,
    // Arbitration ring
    input wire logic tok_inj,
    input wire logic arb_ring_out,
    output logic arb_ring_in,
    // Slot pins
    output logic slot_position_upper,
    output logic slot_position_lower
);
    // Straps are board wiring, so they are plain levels.
    assign slot_position_upper = slot_sel[1];
    assign slot_position_lower = slot_sel[0];
    // With one card the ring closes on itself; the token is back on arb_ring_in four cycles after it left it.
    initial arb_ring_in = 1'b0;
    always @(posedge mclk) arb_ring_in <= arb_ring_out | tok_inj;
endmodule : ssba_bmc_model
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic mclk, rst, slot_position_upper, slot_position_lower, second_die_present, die_bit2_forced;
    logic ncsi_chan_valid, arb_ring_in, ncsi_tx_pending, ncsi_tx_done, fixed_mode_cfg, arp_persist_cfg;
    logic arp_assign_valid, arp_reset_valid, mctp_tx_req, smbus20_mode, secure_en, comp_load;
    logic verify_done, verify_pass, tok_inj, die1_enable, die_conflict, ids_valid, ncsi_match_die0;
    logic ncsi_match_die1, arb_ring_out, ncsi_tx_grant, eeprom_addr_strap_high, eeprom_addr_strap_mid;
    logic eeprom_addr_strap_low, fru_read_enable, smb_addr_valid, arp_participate, arp_resolved;
    logic mctp_tx_grant, mctp_tx_refused, verify_start, comp_run, comp_deny;
    logic [7:0] ncsi_chan_id, fru_addr_wr, fru_addr_rd;
    logic [6:0] fixed_addr_cfg, arp_assign_addr, smb_addr;
    logic [3:0] fw_wr_req, fw_wr_done, inv_req, fw_wr_grant, fw_wr_reject, inv_ack;
    logic [2:0] pkg_id_die0, pkg_id_die1;
    logic [1:0] inv_src, slot_sel;
    ssba_pkg::ssba_pwr_t power_mode;
    ssba_pkg::ssba_addr_type_t smb_addr_type;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    // Row: slot, die0 id, die1 id, eeprom write address.
    logic [15:0] rows [4] = '{16'h04A0, 16'h4DA4, 16'h96A8, 16'hDFAC};

    ssba_top dut (.*);
    ssba_bmc_model bmc (.*);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 1000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
        end
    endtask : chk

    task automatic nx(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : nx

    task automatic restart(input logic [1:0] s);
        @(posedge mclk) {rst, slot_sel} <= {1'b1, s};
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 10 && ids_valid !== 1'b1; i++) nx(1);
    endtask : restart

    task automatic test_done;
        $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst, second_die_present} = 2'h3;
        {die_bit2_forced, ncsi_chan_valid, ncsi_tx_pending, ncsi_tx_done, fixed_mode_cfg} = 5'h00;
        {arp_persist_cfg, arp_assign_valid, arp_reset_valid, mctp_tx_req, smbus20_mode} = 5'h00;
        {secure_en, comp_load, verify_done, verify_pass, tok_inj} = 5'h00;
        {ncsi_chan_id, fixed_addr_cfg, arp_assign_addr, fw_wr_req, fw_wr_done, inv_req, slot_sel} = 36'h0;
        power_mode = ssba_pkg::SSBA_PM_MAIN;
        for (int r = 0; r < 4; r++) begin
            restart(rows[r][15:14]);
            chk("pkg_id_die0", 8'(rows[r][13:11]), 8'(pkg_id_die0));
            chk("pkg_id_die1", 8'(rows[r][10:8]), 8'(pkg_id_die1));
            chk("fru_addr_wr", rows[r][7:0], fru_addr_wr);
            chk("fru_addr_rd", rows[r][7:0] | 8'h01, fru_addr_rd);
            @(posedge mclk) {ncsi_chan_valid, ncsi_chan_id} <= {1'b1, rows[r][10:8], 5'h02};
            @(posedge mclk) ncsi_chan_valid <= 1'b0;
            #1;
            chk("ncsi_match", 8'h01, 8'({ncsi_match_die0, ncsi_match_die1}));
        end
        // A pin that moves after capture must not disturb the ids.
        @(posedge mclk) slot_sel <= 2'h0;
        nx(6);
        chk("pkg_id_die0", 8'h03, 8'(pkg_id_die0));
        @(posedge mclk) fw_wr_req <= 4'h5;
        nx(1);
        chk("fw_wr_grant", 8'h01, 8'(fw_wr_grant));
        chk("fw_wr_reject", 8'h04, 8'(fw_wr_reject));
        @(posedge mclk) fw_wr_req <= 4'hD;
        nx(1);
        chk("fw_wr_reject", 8'h08, 8'(fw_wr_reject));
        chk("fw_wr_grant", 8'h01, 8'(fw_wr_grant));
        @(posedge mclk) {fw_wr_req, fw_wr_done} <= {4'hC, 4'h1};
        @(posedge mclk) fw_wr_done <= 4'h0;
        for (int i = 0; i < 5 && fw_wr_grant !== 4'h4; i++) nx(1);
        chk("fw_wr_grant", 8'h04, 8'(fw_wr_grant));
        @(posedge mclk) {fw_wr_req, inv_req} <= {4'h0, 4'h5};
        nx(1);
        chk("inv_ack", 8'h01, 8'(inv_ack));
        @(posedge mclk) inv_req <= 4'h0;
        #1;
        chk("inv_ack", 8'h04, 8'(inv_ack));
        for (int p = 1; p >= 0; p--) begin
            @(posedge mclk) {arp_assign_valid, arp_assign_addr, arp_persist_cfg} <= {1'b1, 7'h3A, 1'(p)};
            @(posedge mclk) arp_assign_valid <= 1'b0;
            #1;
            chk("smb_addr", 8'h3A, 8'(smb_addr));
            chk("smb_addr_type", p ? 8'(ssba_pkg::SSBA_AT_DYN_PERSIST) : 8'(ssba_pkg::SSBA_AT_DYN_VOLATILE),
                8'(smb_addr_type));
            @(posedge mclk) arp_reset_valid <= 1'b1;
            @(posedge mclk) arp_reset_valid <= 1'b0;
            #1;
            chk("smb_addr_valid", 8'(p), 8'(smb_addr_valid));
        end
        @(posedge mclk) {fixed_mode_cfg, fixed_addr_cfg, arp_assign_valid} <= {1'b1, 7'h22, 1'b1};
        @(posedge mclk) arp_assign_valid <= 1'b0;
        #1;
        chk("smb_addr", 8'h22, 8'(smb_addr));
        chk("smb_addr_type", 8'(ssba_pkg::SSBA_AT_FIXED), 8'(smb_addr_type));
        for (int m = 0; m < 2; m++) begin
            @(posedge mclk) {mctp_tx_req, smbus20_mode} <= {1'b1, 1'(m)};
            nx(1);
            chk("mctp", m ? 8'h02 : 8'h01, 8'({mctp_tx_grant, mctp_tx_refused}));
        end
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk) {mctp_tx_req, power_mode} <= {1'b0, ssba_pkg::ssba_pwr_t'(m)};
            nx(1);
            chk("fru_read_enable", 8'(m != 0), 8'(fru_read_enable));
        end
        for (int v = 0; v < 2; v++) begin
            @(posedge mclk) {secure_en, comp_load} <= 2'h3;
            @(posedge mclk) comp_load <= 1'b0;
            #1;
            chk("verify_start", 8'h01, 8'(verify_start));
            @(posedge mclk) {verify_done, verify_pass} <= {1'b1, 1'(v)};
            @(posedge mclk) verify_done <= 1'b0;
            #1;
            chk("run_deny", v ? 8'h02 : 8'h01, 8'({comp_run, comp_deny}));
        end
        @(posedge mclk) {ncsi_tx_pending, tok_inj} <= 2'h3;
        @(posedge mclk) tok_inj <= 1'b0;
        for (int i = 0; i < 8 && ncsi_tx_grant !== 1'b1; i++) nx(1);
        chk("ncsi_tx_grant", 8'h01, 8'(ncsi_tx_grant));
        @(posedge mclk) {ncsi_tx_pending, ncsi_tx_done} <= 2'h1;
        @(posedge mclk) ncsi_tx_done <= 1'b0;
        #1;
        chk("ncsi_tx_grant", 8'h00, 8'(ncsi_tx_grant));
        @(posedge mclk) die_bit2_forced <= 1'b1;
        restart(2'h1);
        nx(1);
        chk("die1_en_conflict", 8'h01, 8'({die1_enable, die_conflict}));
        test_done();
    end
endmodule : testbench
`default_nettype wire
